// [lcl_cell.sv]
// configurable logic cell with its AXI4-Lite register file
// assumes all peripheral, clock and pin inputs are synchronous to clk
//
// How it works
// - modes 000-010 are AND-OR, OR-XOR, AND4
// - mode 011 is an SR latch
// - 100 D flip-flop S/R; 101 two-input D R
// - 110 JK flip-flop R; 111 transparent latch S/R
// - gate inversion bit flips that gate output
// - four 3-bit selectors in selector register
// - selector code 101 gives constant low
// - selector 1 source map
// - selector 2 source map
// - selector 3 source map
// - selector 4 source map
// - true enable admits the plain channel
// - negated enable admits the inverted channel
// - unused control bits read zero
// - gate ORs all its enabled terms
// - disabled cell drives all outputs low
// - output invert bit flips final output
// - edge events on rising and falling output
`timescale 1ns/10ps
`default_nettype none
`include "lcl_params.svh"

module lcl_cell (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire lcl_pkg::lcl_addr_t awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire lcl_pkg::lcl_word_t wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire lcl_pkg::lcl_addr_t araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output lcl_pkg::lcl_word_t rdata,
  output logic [1:0] rresp,
  // pins and clock sources
  input wire logic inputPinA,
  input wire logic inputPinB,
  input wire logic instructionCycleClock,
  input wire logic secondaryOscillator,
  input wire logic lowPowerRcClock,
  input wire logic fastRcClock,
  // peripheral events
  input wire logic compare1EventFlag,
  input wire logic compare2EventFlag,
  input wire logic compare3EventFlag,
  input wire logic compare4EventFlag,
  input wire logic compare5EventFlag,
  input wire logic otherCellOut,
  input wire logic comparator1Out,
  input wire logic comparator2Out,
  input wire logic comparator3Out,
  input wire logic uartTx,
  input wire logic uartRx,
  input wire logic spiSdo,
  input wire logic spiSdi,
  input wire logic adcConversionDone,
  input wire logic chargeTimeTrigger,
  // cell results
  output logic cellOut,
  output logic portPinOut,
  output logic portPinOe,
  output logic riseEdgeIrq,
  output logic fallEdgeIrq
);
  import lcl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // write only the enabled byte lanes and only the implemented bits
  function automatic lcl_reg_t mergeWrite(lcl_reg_t old, lcl_word_t data,
                                          logic [3:0] strb, lcl_reg_t mask);
    lcl_reg_t merged;
    merged = old;
    if (strb[0]) begin
      merged[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = data[15:8];
    end
    return merged & mask;
  endfunction

  // eight-way source pick; code 101 is wired to zero by the callers
  function automatic logic pickSource(lcl_sel_t code, logic [7:0] srcs);
    return srcs[code];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register and bus state

  lcl_reg_t ctrlLow_reg, ctrlLow_next;
  lcl_reg_t gatePol_reg, gatePol_next;
  lcl_reg_t srcSel_reg, srcSel_next;
  lcl_reg_t gateEnLow_reg, gateEnLow_next;
  lcl_reg_t gateEnHigh_reg, gateEnHigh_next;
  logic awHeld_reg, awHeld_next;
  lcl_addr_t awAddr_reg, awAddr_next;
  logic wHeld_reg, wHeld_next;
  lcl_word_t wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic rValid_reg, rValid_next;
  lcl_word_t rData_reg, rData_next;
  logic [1:0] rResp_reg, rResp_next;

  logic cellOut_reg, cellOut_next;
  logic state_reg, state_next;
  logic clkPrev_reg, clkPrev_next;
  logic rise_reg, rise_next;
  logic fall_reg, fall_next;

  logic awHave, wHave, doWrite;
  lcl_addr_t wrAddr;
  lcl_word_t wrData;
  logic [3:0] wrStrb;
  lcl_reg_t readVal;
  logic readHit;

  // handshake readies are combinational from held state
  assign awready = !awHeld_reg && !bValid_reg;
  assign wready = !wHeld_reg && !bValid_reg;
  assign arready = !rValid_reg;
  assign bvalid = bValid_reg;
  assign bresp = bResp_reg;
  assign rvalid = rValid_reg;
  assign rdata = rData_reg;
  assign rresp = rResp_reg;

  // read decode; the output state bit reflects the live cell
  always_comb begin
    readHit = 1'b1;
    readVal = `LCL_RST_REG;
    unique case (araddr)
      `LCL_OFS_CTRL_LOW: begin
        readVal = ctrlLow_reg;
        readVal[`LCL_BIT_OUT_STATE] = cellOut_reg;
      end
      `LCL_OFS_GATE_POL: readVal = gatePol_reg;
      `LCL_OFS_SRC_SEL: readVal = srcSel_reg;
      `LCL_OFS_GATE_EN_LOW: readVal = gateEnLow_reg;
      `LCL_OFS_GATE_EN_HIGH: readVal = gateEnHigh_reg;
      default: readHit = 1'b0;
    endcase
  end

  // address and data may come in either order; write fires in the cycle that both are held or being accepted
  always_comb begin
    awHave = awHeld_reg || (awvalid && awready);
    wHave = wHeld_reg || (wvalid && wready);
    wrAddr = awHeld_reg ? awAddr_reg : awaddr;
    wrData = wHeld_reg ? wData_reg : wdata;
    wrStrb = wHeld_reg ? wStrb_reg : wstrb;
    doWrite = awHave && wHave && !bValid_reg;
    awAddr_next = (awvalid && awready) ? awaddr : awAddr_reg;
    wData_next = (wvalid && wready) ? wdata : wData_reg;
    wStrb_next = (wvalid && wready) ? wstrb : wStrb_reg;
    awHeld_next = doWrite ? 1'b0 : awHave;
    wHeld_next = doWrite ? 1'b0 : wHave;
    bValid_next = bValid_reg && !bready;
    bResp_next = bResp_reg;
    ctrlLow_next = ctrlLow_reg;
    gatePol_next = gatePol_reg;
    srcSel_next = srcSel_reg;
    gateEnLow_next = gateEnLow_reg;
    gateEnHigh_next = gateEnHigh_reg;
    if (doWrite) begin
      bValid_next = 1'b1;
      bResp_next = `LCL_RESP_OKAY;
      unique case (wrAddr)
        `LCL_OFS_CTRL_LOW:
          ctrlLow_next = mergeWrite(ctrlLow_reg, wrData, wrStrb, `LCL_MASK_CTRL_LOW);
        `LCL_OFS_GATE_POL:
          gatePol_next = mergeWrite(gatePol_reg, wrData, wrStrb, `LCL_MASK_GATE_POL);
        `LCL_OFS_SRC_SEL:
          srcSel_next = mergeWrite(srcSel_reg, wrData, wrStrb, `LCL_MASK_SRC_SEL);
        `LCL_OFS_GATE_EN_LOW:
          gateEnLow_next = mergeWrite(gateEnLow_reg, wrData, wrStrb, `LCL_MASK_GATE_EN);
        `LCL_OFS_GATE_EN_HIGH:
          gateEnHigh_next = mergeWrite(gateEnHigh_reg, wrData, wrStrb, `LCL_MASK_GATE_EN);
        default: bResp_next = `LCL_RESP_SLVERR;
      endcase
    end
  end

  // one read in flight; data is captured when the address is taken
  always_comb begin
    rValid_next = rValid_reg && !rready;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    if (arvalid && arready) begin
      rValid_next = 1'b1;
      rData_next = {16'h0000, readVal};
      rResp_next = readHit ? `LCL_RESP_OKAY : `LCL_RESP_SLVERR;
    end
  end

  // every control field starts at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlLow_reg <= `LCL_RST_REG;
      gatePol_reg <= `LCL_RST_REG;
      srcSel_reg <= `LCL_RST_REG;
      gateEnLow_reg <= `LCL_RST_REG;
      gateEnHigh_reg <= `LCL_RST_REG;
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= 2'h0;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= 2'h0;
    end else begin
      ctrlLow_reg <= ctrlLow_next;
      gatePol_reg <= gatePol_next;
      srcSel_reg <= srcSel_next;
      gateEnLow_reg <= gateEnLow_next;
      gateEnHigh_reg <= gateEnHigh_next;
      awHeld_reg <= awHeld_next;
      awAddr_reg <= awAddr_next;
      wHeld_reg <= wHeld_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      rValid_reg <= rValid_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection and input gates

  logic [7:0] srcs1, srcs2, srcs3, srcs4;
  logic [3:0] chanData;
  logic [3:0] gateOut;
  logic cellEnable;
  lcl_mode_t mode;

  assign cellEnable = ctrlLow_reg[`LCL_BIT_ENABLE];
  assign mode = lcl_mode_t'(ctrlLow_reg[`LCL_MODE_LSB +: 3]);

  // code 101 is the constant low in every selector
  assign srcs1 = {compare5EventFlag, compare4EventFlag, 1'b0, fastRcClock,
                  lowPowerRcClock, secondaryOscillator, instructionCycleClock,
                  inputPinA};
  assign srcs2 = {compare2EventFlag, compare1EventFlag, 1'b0, adcConversionDone,
                  uartTx, comparator1Out, otherCellOut, inputPinB};
  assign srcs3 = {compare3EventFlag, compare2EventFlag, 1'b0, uartRx,
                  spiSdo, comparator2Out, cellOut_reg, inputPinA};
  assign srcs4 = {compare3EventFlag, compare1EventFlag, 1'b0, chargeTimeTrigger,
                  spiSdi, comparator3Out, otherCellOut, inputPinB};

  assign chanData[0] = pickSource(srcSel_reg[`LCL_SEL1_LSB +: 3], srcs1);
  assign chanData[1] = pickSource(srcSel_reg[`LCL_SEL2_LSB +: 3], srcs2);
  assign chanData[2] = pickSource(srcSel_reg[`LCL_SEL3_LSB +: 3], srcs3);
  assign chanData[3] = pickSource(srcSel_reg[`LCL_SEL4_LSB +: 3], srcs4);

  // gates 1,2 enables in the low register, 3,4 in the high one
  for (genvar g = 0; g < 4; g++) begin : gGate
    lcl_gate uGate (
      .chanData(chanData),
      .chanEnable(g < 2 ? gateEnLow_reg[8*(g%2) +: 8] : gateEnHigh_reg[8*(g%2) +: 8]),
      .gateInvert(gatePol_reg[g]),
      .gateOut(gateOut[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // cell function

  logic g1, g2, g3, g4, clkRise, func;

  assign g1 = gateOut[0];
  assign g2 = gateOut[1];
  assign g3 = gateOut[2];
  assign g4 = gateOut[3];
  // flip-flop modes clock on a rising gate 1, sampled by the system clock
  assign clkRise = g1 && !clkPrev_reg;

  // storage and combinational result; resets are dominant over sets
  always_comb begin
    state_next = state_reg;
    func = 1'b0;
    unique case (mode)
      LCL_AND_OR: func = (g1 & g2) | (g3 & g4);
      LCL_OR_XOR: func = (g1 | g2) ^ (g3 | g4);
      LCL_AND4: func = g1 & g2 & g3 & g4;
      LCL_SR_LATCH: begin
        if (g3 | g4) begin
          state_next = 1'b0;
        end else if (g1 | g2) begin
          state_next = 1'b1;
        end
        func = state_next;
      end
      LCL_DFF_SR: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (g4) begin
          state_next = 1'b1;
        end else if (clkRise) begin
          state_next = g2;
        end
        func = state_next;
      end
      LCL_DFF2_R: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (clkRise) begin
          state_next = g2 & g4;
        end
        func = state_next;
      end
      LCL_JK_R: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (clkRise) begin
          state_next = (g2 & ~state_reg) | (~g4 & state_reg);
        end
        func = state_next;
      end
      LCL_DLATCH_SR: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (g4) begin
          state_next = 1'b1;
        end else if (g1) begin
          state_next = g2;
        end
        func = state_next;
      end
    endcase
    if (!cellEnable) begin
      state_next = 1'b0;
    end
  end

  // output polarity, disable and edge events
  always_comb begin
    clkPrev_next = g1;
    cellOut_next = cellEnable ? (func ^ ctrlLow_reg[`LCL_BIT_OUT_INVERT]) : 1'b0;
    rise_next = cellEnable && ctrlLow_reg[`LCL_BIT_RISE_IRQ_EN]
                && cellOut_next && !cellOut_reg;
    fall_next = cellEnable && ctrlLow_reg[`LCL_BIT_FALL_IRQ_EN]
                && !cellOut_next && cellOut_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= 1'b0;
      clkPrev_reg <= 1'b0;
      cellOut_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      clkPrev_reg <= clkPrev_next;
      cellOut_reg <= cellOut_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  // a disabled cell shows zero on every output
  assign cellOut = cellOut_reg;
  assign portPinOut = cellOut_reg;
  assign portPinOe = cellEnable && ctrlLow_reg[`LCL_BIT_PORT_EN];
  assign riseEdgeIrq = rise_reg;
  assign fallEdgeIrq = fall_reg;

endmodule
`default_nettype wire

// [lcl_cell_props.sv]
// assertions on the logic cell ports: bus hand-over and output event pulses
// assumes lcl_pkg is compiled first; bound to every lcl_cell instance
`timescale 1ns/10ps
`default_nettype none

module lcl_cell_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire lcl_pkg::lcl_word_t rdata,
  // cell results
  input wire logic cellOut,
  input wire logic portPinOut,
  input wire logic riseEdgeIrq,
  input wire logic fallEdgeIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // event pulses must sit on the output edge that caused them
  a_rise_on_edge: assert property (riseEdgeIrq |-> $rose(cellOut))
    else $error("rise pulse without a rising output");
  a_fall_on_edge: assert property (fallEdgeIrq |-> $fell(cellOut))
    else $error("fall pulse without a falling output");
  a_rise_single: assert property (riseEdgeIrq |=> !riseEdgeIrq)
    else $error("rise pulse longer than one cycle");
  // the pin copy never disagrees with the cell result
  a_pin_mirror: assert property (portPinOut == cellOut)
    else $error("pin output differs from cell output");

  //////////////////////////////////////////////////////////////////////////////
  // answers stand until taken; a stall must not lose them
  a_resp_held: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before taken");
  a_resp_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_read_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  a_write_refuse: assert property (bvalid |-> !awready)
    else $error("write address taken while response pending");

  // main scenarios reached
  c_rise: cover property (riseEdgeIrq);
  c_fall: cover property (fallEdgeIrq);
  c_write: cover property (bvalid && bready);
endmodule

bind lcl_cell lcl_cell_props lcl_cell_props_inst (.clk, .rst, .awready, .bvalid, .bready,
  .arready, .rvalid, .rready, .rdata, .cellOut, .portPinOut, .riseEdgeIrq, .fallEdgeIrq);

`default_nettype wire

// [lcl_gate.sv]
// one input gate of the logic cell: OR of enabled true and negated channels
// assumes the four channel signals are already selected and synchronous
`timescale 1ns/10ps
`default_nettype none

module lcl_gate (
  // selected channel data
  input wire logic [3:0] chanData,
  // enables, bit 2k+1 true and bit 2k negated for channel k
  input wire logic [7:0] chanEnable,
  input wire logic gateInvert,
  // gate result into the cell function
  output logic gateOut
);

  logic orTerm;

  // nothing enabled leaves the OR at zero before inversion
  always_comb begin
    orTerm = 1'b0;
    for (int k = 0; k < 4; k++) begin
      orTerm = orTerm | (chanEnable[2*k+1] & chanData[k]);
      orTerm = orTerm | (chanEnable[2*k] & ~chanData[k]);
    end
  end

  assign gateOut = orTerm ^ gateInvert;

endmodule
`default_nettype wire

// [lcl_params.svh]
// constants for the configurable logic cell: register offsets, field places, resets
// assumes it is included by bare name from the package and the cell module
`ifndef LCL_PARAMS_SVH
`define LCL_PARAMS_SVH

// register byte offsets on the control bus
`define LCL_OFS_CTRL_LOW 8'h00
`define LCL_OFS_GATE_POL 8'h04
`define LCL_OFS_SRC_SEL 8'h08
`define LCL_OFS_GATE_EN_LOW 8'h0C
`define LCL_OFS_GATE_EN_HIGH 8'h10

// writable bits of each register; everything else reads back as zero, save the output state bit 6 of the low control register
`define LCL_MASK_CTRL_LOW 16'h8CA7
`define LCL_MASK_GATE_POL 16'h000F
`define LCL_MASK_SRC_SEL 16'h7777
`define LCL_MASK_GATE_EN 16'hFFFF

// reset values
`define LCL_RST_REG 16'h0000

// fields of the low control register
`define LCL_BIT_ENABLE 15
`define LCL_BIT_RISE_IRQ_EN 11
`define LCL_BIT_FALL_IRQ_EN 10
`define LCL_BIT_PORT_EN 7
`define LCL_BIT_OUT_STATE 6
`define LCL_BIT_OUT_INVERT 5
`define LCL_MODE_LSB 0

// source selector field places
`define LCL_SEL1_LSB 0
`define LCL_SEL2_LSB 4
`define LCL_SEL3_LSB 8
`define LCL_SEL4_LSB 12

// cell function codes
`define LCL_MODE_AND_OR 3'h0
`define LCL_MODE_OR_XOR 3'h1
`define LCL_MODE_AND4 3'h2
`define LCL_MODE_SR_LATCH 3'h3
`define LCL_MODE_DFF_SR 3'h4
`define LCL_MODE_DFF2_R 3'h5
`define LCL_MODE_JK_R 3'h6
`define LCL_MODE_DLATCH_SR 3'h7

// bus answers
`define LCL_RESP_OKAY 2'h0
`define LCL_RESP_SLVERR 2'h2

`endif

// [lcl_pkg.sv]
// types shared by the configurable logic cell files
// assumes lcl_params.svh is on the include path
`include "lcl_params.svh"

package lcl_pkg;
  typedef logic [15:0] lcl_reg_t;
  typedef logic [31:0] lcl_word_t;
  typedef logic [7:0] lcl_addr_t;
  typedef logic [2:0] lcl_sel_t;
  typedef enum logic [2:0] {
    LCL_AND_OR = `LCL_MODE_AND_OR,
    LCL_OR_XOR = `LCL_MODE_OR_XOR,
    LCL_AND4 = `LCL_MODE_AND4,
    LCL_SR_LATCH = `LCL_MODE_SR_LATCH,
    LCL_DFF_SR = `LCL_MODE_DFF_SR,
    LCL_DFF2_R = `LCL_MODE_DFF2_R,
    LCL_JK_R = `LCL_MODE_JK_R,
    LCL_DLATCH_SR = `LCL_MODE_DLATCH_SR
  } lcl_mode_t;
endpackage

// [lcl_src_model.sv]
// level sources feeding the cell: pins, clock sources and peripheral events
// assumes the bench drives the pattern just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none

module lcl_src_model (
  // one bit per source, bit 0 first in the port list below
  input wire logic [20:0] srcDrive,
  // pins and clock sources
  output logic inputPinA,
  output logic inputPinB,
  output logic instructionCycleClock,
  output logic secondaryOscillator,
  output logic lowPowerRcClock,
  output logic fastRcClock,
  // peripheral events
  output logic compare1EventFlag,
  output logic compare2EventFlag,
  output logic compare3EventFlag,
  output logic compare4EventFlag,
  output logic compare5EventFlag,
  output logic otherCellOut,
  output logic comparator1Out,
  output logic comparator2Out,
  output logic comparator3Out,
  output logic uartTx,
  output logic uartRx,
  output logic spiSdo,
  output logic spiSdi,
  output logic adcConversionDone,
  output logic chargeTimeTrigger
);
  // every source is a plain level, so the pattern maps straight through
  assign {chargeTimeTrigger, adcConversionDone, spiSdi, spiSdo, uartRx, uartTx,
    comparator3Out, comparator2Out, comparator1Out, otherCellOut, compare5EventFlag,
    compare4EventFlag, compare3EventFlag, compare2EventFlag, compare1EventFlag, fastRcClock,
    lowPowerRcClock, secondaryOscillator, instructionCycleClock, inputPinB, inputPinA} = srcDrive;
endmodule

`default_nettype wire

// [tb.sv]
// self-checking bench for the logic cell: registers, gates, selectors, cell functions
// assumes design, source model and checker are compiled before it
`timescale 1ns/10ps
`default_nettype none

module tb;
  import lcl_pkg::*;
  logic clk = 1'h0, rst = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, cellOut, portPinOut, portPinOe;
  logic riseEdgeIrq, fallEdgeIrq;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  lcl_addr_t awaddr = 8'h00, araddr = 8'h00;
  lcl_word_t wdata = 32'h0, rdata;
  logic [20:0] srcDrive = 21'h0;
  wire logic inputPinA, inputPinB, instructionCycleClock, secondaryOscillator, lowPowerRcClock;
  wire logic fastRcClock, compare1EventFlag, compare2EventFlag, compare3EventFlag;
  wire logic compare4EventFlag, compare5EventFlag, otherCellOut, comparator1Out, comparator2Out;
  wire logic comparator3Out, uartTx, uartRx, spiSdo, spiSdi, adcConversionDone, chargeTimeTrigger;
  int miscompares = 0, total_checks = 0, riseCnt = 0, fallCnt = 0;
  // source bit per channel and code; 31 is the constant low, 30 the cell's own output
  int srcMap [32] = '{0, 2, 3, 4, 5, 31, 9, 10, 1, 11, 12, 15, 19, 31, 6, 7,
    0, 30, 13, 17, 16, 31, 7, 8, 1, 11, 14, 18, 20, 31, 6, 8};

  //////////////////////////////////////////////////////////////////////////////
  // clock and event pulse counters
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    riseCnt <= riseCnt + int'(riseEdgeIrq);
    fallCnt <= fallCnt + int'(fallEdgeIrq);
  end

  lcl_cell lcl_cell_inst (.clk, .rst, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .inputPinA, .inputPinB,
    .instructionCycleClock, .secondaryOscillator, .lowPowerRcClock, .fastRcClock,
    .compare1EventFlag, .compare2EventFlag, .compare3EventFlag, .compare4EventFlag,
    .compare5EventFlag, .otherCellOut, .comparator1Out, .comparator2Out, .comparator3Out,
    .uartTx, .uartRx, .spiSdo, .spiSdi, .adcConversionDone, .chargeTimeTrigger, .cellOut,
    .portPinOut, .portPinOe, .riseEdgeIrq, .fallEdgeIrq);
  lcl_src_model lcl_src_model_inst (.srcDrive, .inputPinA, .inputPinB, .instructionCycleClock,
    .secondaryOscillator, .lowPowerRcClock, .fastRcClock, .compare1EventFlag,
    .compare2EventFlag, .compare3EventFlag, .compare4EventFlag, .compare5EventFlag,
    .otherCellOut, .comparator1Out, .comparator2Out, .comparator3Out, .uartTx, .uartRx,
    .spiSdo, .spiSdi, .adcConversionDone, .chargeTimeTrigger);

  //////////////////////////////////////////////////////////////////////////////
  // comparison, bus cycles and stimulus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // bready is raised late on purpose so the response must stand through a stall
  task automatic wr(input lcl_addr_t a, input lcl_reg_t d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h1;
    @(posedge clk);
    chk(bresp, er, "bresp");
    bready <= 1'h0;
  endtask
  task automatic rd(input lcl_addr_t a, input lcl_word_t ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h1;
    @(posedge clk);
    chk(rdata, ed, "rdata");
    chk(rresp, er, "rresp");
    rready <= 1'h0;
  endtask
  task automatic cfg(input lcl_reg_t c, p, s, l, h);
    wr(8'h00, 16'h0000, 2'h0);
    wr(8'h04, p, 2'h0);
    wr(8'h08, s, 2'h0);
    wr(8'h0C, l, 2'h0);
    wr(8'h10, h, 2'h0);
    wr(8'h00, c, 2'h0);
  endtask
  // three edges cover the one-register cell path plus the sampled flip-flop clock
  task automatic step(input logic [20:0] s);
    srcDrive <= s;
    repeat (3) @(posedge clk);
  endtask
  // gate n follows channel n, channels 2-4 on the comparators
  function automatic logic [20:0] gs(input logic [3:0] g);
    return {6'h00, g[3:1], 11'h000, g[0]};
  endfunction
  task automatic zeros;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, 2'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    zeros();
    rd(8'h14, 32'h0, 2'h2);
    wr(8'h14, 16'hFFFF, 2'h2);
    wr(8'h04, 16'hFFFF, 2'h0);
    rd(8'h04, 32'h0000000F, 2'h0);
    wr(8'h08, 16'hFFFF, 2'h0);
    rd(8'h08, 32'h00007777, 2'h0);
    wstrb <= 4'h1;
    wr(8'h0C, 16'hFFFF, 2'h0);
    wstrb <= 4'hF;
    rd(8'h0C, 32'h000000FF, 2'h0);
    $display("regs done");
  endtask
  task automatic t_gate;
    for (int k = 0; k < 4; k++)
      for (int t = 0; t < 2; t++) begin
        cfg(16'h8002, 16'h000E, 16'h0000, 16'(1 << (2 * k + t)), 16'h0000);
        for (int v = 0; v < 2; v++) begin
          step(21'(v << (k % 2)));
          chk(cellOut, 32'(v == t), "gate");
        end
      end
    $display("gate done");
  endtask
  task automatic t_sel;
    for (int k = 0; k < 4; k++)
      for (int c = 0; c < 8; c++) begin
        int x;
        x = srcMap[8 * k + c];
        if (x != 30) begin
          cfg(16'h8002, 16'h000E, 16'(c << (4 * k)), 16'(2 << (2 * k)), 16'h0000);
          step(x < 21 ? 21'(1 << x) : 21'h0);
          chk(cellOut, 32'(x < 21), "sel");
          step(x < 21 ? ~21'(1 << x) : 21'h1FFFFF);
          chk(cellOut, 32'h0, "sel");
        end
      end
    // own output on channel 3 holds a one through gate 1 after pin A drops
    step(21'h0);
    cfg(16'h8001, 16'h0000, 16'h0100, 16'h0220, 16'h0000);
    chk(cellOut, 32'h0, "own");
    step(21'h1);
    step(21'h0);
    chk(cellOut, 32'h1, "own");
    $display("sel done");
  endtask
  task automatic t_comb;
    for (int m = 0; m < 3; m++)
      for (int i = 0; i < 2; i++) begin
        cfg(16'h8080 | 16'(i << 5) | 16'(m), 16'h0000, 16'h2220, 16'h0802, 16'h8020);
        chk(portPinOe, 32'h1, "oe");
        for (int g = 0; g < 16; g++) begin
          logic [3:0] b;
          logic e;
          b = 4'(g);
          e = m == 0 ? (b[0] & b[1]) | (b[2] & b[3]) : m == 1 ? (b[0] | b[1]) ^ (b[2] | b[3]) : &b;
          step(gs(b));
          chk(cellOut, 32'(e ^ i[0]), "comb");
        end
      end
    wr(8'h00, 16'h00A0, 2'h0);
    step(gs(4'h0));
    chk(cellOut, 32'h0, "off");
    chk(portPinOe, 32'h0, "off");
    $display("comb done");
  endtask
  // each byte of s is one step: high nibble expected output, low nibble gates 4..1
  task automatic seq(input logic [2:0] m, input logic [63:0] s, input int n);
    step(gs(4'h0));
    cfg(16'h8000 | 16'(m), 16'h0000, 16'h2220, 16'h0802, 16'h8020);
    for (int i = n - 1; i >= 0; i--) begin
      step(gs(s[8 * i +: 4]));
      chk(cellOut, 32'(s[8 * i + 4]), "seq");
    end
    $display("seq done");
  endtask
  task automatic t_edge;
    int r0, f0;
    cfg(16'h8C02, 16'h000E, 16'h0000, 16'h0002, 16'h0000);
    step(gs(4'h0));
    r0 = riseCnt;
    f0 = fallCnt;
    repeat (3) begin
      step(gs(4'h1));
      step(gs(4'h0));
    end
    wr(8'h00, 16'h8002, 2'h0);
    step(gs(4'h1));
    rd(8'h00, 32'h00008042, 2'h0);
    step(gs(4'h0));
    chk(riseCnt - r0, 32'h3, "rise");
    chk(fallCnt - f0, 32'h3, "fall");
    $display("edge done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_gate();
    t_sel();
    t_comb();
    seq(3'h3, 64'h111004000512, 6);
    seq(3'h4, 64'h0213121001180C, 7);
    seq(3'h5, 64'h0A1B1A12030A1B04, 8);
    seq(3'h6, 64'h021318090A1B1A0B, 8);
    seq(3'h7, 64'h13011312100418, 7);
    t_edge();
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    zeros();
    close_out();
  end
  // roughly five times the expected run length of under two thousand cycles
  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule

`default_nettype wire
